// *** core/cbw_consts.svh ***
`ifndef CBW_CONSTS_SVH
`define CBW_CONSTS_SVH
// AXI byte addresses of the register words
`define CTL_ONE_ADDR 12'h000
`define CTL_TWO_ADDR 12'h004
`define UNIT_LIMIT_ADDR 12'h008
`define WRAP_LEN_ADDR 12'h00c
`define FAIL_STAT_ADDR 12'h020
`define EVENT_STAT_ADDR 12'h028
`define MEDIA_CFG_ADDR 12'h030
// Printed register indices
`define CTL_TWO_IDX 16'h1001
`define FAIL_STAT_IDX 16'h1008
`define EVENT_STAT_IDX 16'h100a
// Control-one bits
`define C1_AUTO 7
`define C1_AUTOMATIC_STATUS_WRAPPER_ENABLE 6
`define C1_ONCE 5
`define C1_TAIL_MODE 2
`define C1_RESERVED_CHECK_ENABLE 1
`define C1_SOFT_RST 0
// Control-two bits and reset value
`define C2_JOIN 2
`define C2_ABORT 1
`define C2_SINGLE 0
`define C2_RESET 8'h04
`define C2_MASK 8'h05
// Event status bits
`define EV_TAIL 6
`define EV_UNIT_OFF 5
`define EV_CB_LEN 4
`define EV_CAP 3
`define EV_IDLE 2
`define EV_PKT_LEN 1
`define EV_ONCE 0
// Timing
`define TAIL_TIMEOUT_NS 1000000
`define CLK_PERIOD_NS 10
`define TAIL_TIMEOUT_CYC (`TAIL_TIMEOUT_NS / `CLK_PERIOD_NS)
`define AES_PARAM_NS 300
`define AES_PARAM_CYC (`AES_PARAM_NS / `CLK_PERIOD_NS)
`endif

// *** core/cbw_pkg.sv ***
package cbw_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_TAIL = 5'b00100,
    ST_XFER = 5'b01000,
    ST_DONE = 5'b10000
  } cbw_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage : cbw_pkg

// *** core/cbw_w1c_reg.sv ***
`timescale 1ns/100ps
`default_nettype none
module cbw_w1c_reg #(
  parameter int WIDTH = 8
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clr_in,
  output logic [WIDTH-1:0] flags_out
);
  // Set beats clear in the same cycle
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      flags_out <= '0;
    else
      flags_out <= (flags_out & ~clr_in) | set_in;
  end
endmodule : cbw_w1c_reg
`default_nettype wire

// *** core/cbw_timeout.sv ***
`timescale 1ns/100ps
`default_nettype none
module cbw_timeout #(
  parameter int COUNT = 100000
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic run_in,
  input wire logic restart_in,
  output logic expired_out
);
  logic [31:0] cnt_q;
  // Counts while armed, restarts on media activity
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in || restart_in || !run_in)
      cnt_q <= '0;
    else if (cnt_q != 32'(COUNT))
      cnt_q <= cnt_q + 32'h1;
  end
  assign expired_out = run_in && !restart_in && (cnt_q == 32'(COUNT - 1));
endmodule : cbw_timeout
`default_nettype wire

// *** core/cbw_processor.sv ***
// Overview of operation
// - Single-command bit runs one wrapper, self-clears
// - Single-command completion raises done interrupt
// - Transfer-in-progress also drives activity LED
// - Tail request on timeout, break, errors
// - Wrapper error: tail first, error after clear
// - Tail raised at wrapper check stalls processor until cleared
// - Control-two bit 2 joins same-endpoint buffers
// - Control-two bit 1 aborts AES frame
// - Control-two bit 0 posts single OUT buffer
// - Otherwise keep two OUT buffers posted
// - AES parameters delivered within 300 ns
// - Failure flags: phase to signature, bit order
// - Failure flags only with automatic processing
// - Writing one clears a status bit
// - Any failure bit raises combined interrupt
// - Event bits 6 to 3: tail, unit, length, cap
// - Event bit 2: idle with automatic off
// - Event bit 1: wrapper length mismatch
// - Event bit 0: single or no-status completion
// - Reserved-check enable flags nonzero reserved bits
// - Unit id above limit is an error
`timescale 1ns/100ps
`default_nettype none
`include "cbw_consts.svh"
module cbw_processor import cbw_pkg::*; #(
  parameter int TAIL_TIMEOUT = `TAIL_TIMEOUT_CYC
) (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial engine side
  input wire logic wrapper_rx_in,
  input wire logic [5:0] wrapper_len_in,
  input wire logic [3:0] wrapper_unit_in,
  input wire logic wrapper_rsv_nonzero_in,
  input wire logic wrapper_sig_bad_in,
  input wire logic wrapper_cb_len_bad_in,
  input wire logic wrapper_xfer_len_bad_in,
  input wire logic wrapper_scsi_bad_in,
  input wire logic wrapper_cap_bad_in,
  input wire logic wrapper_wp_bad_in,
  input wire logic wrapper_continues_in,
  input wire logic phase_err_in,
  input wire logic data_err_in,
  input wire logic xfer_err_in,
  input wire logic xfer_done_in,
  input wire logic media_access_in,
  input wire logic out_buf_taken_in,
  output logic out_buf_post_out,
  output logic [1:0] out_bufs_posted_out,
  output logic buffer_join_enable_out,
  output logic aes_abort_out,
  output logic aes_param_load_out,
  output logic start_xfer_out,
  output logic status_wrapper_send_out,
  output logic transfer_in_progress_out,
  output logic activity_led_out,
  output logic single_command_done_irq_out,
  output logic command_processor_irq_out,
  output logic event_irq_out
);
  // ****************************************************
  // Register state
  // ****************************************************
  reg_byte_t ctl_one_q;
  reg_byte_t ctl_two_q;
  logic [3:0] unit_count_limit_q;
  logic [5:0] expected_wrapper_length_q;
  logic [15:0] unit_enable_q;
  logic [7:0] fail_set, fail_clr, fail_q;
  logic [7:0] ev_set, ev_clr, ev_q;
  cbw_state_t state_q;
  logic wr_fire, rd_fire;
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic aw_have_q, w_have_q;
  logic tail_err_pend_q;
  logic [7:0] held_fail_q;
  logic [7:0] held_ev_q;
  logic once_run_q;
  logic timeout_hit;
  logic auto_on;

  function automatic logic wr_byte0(input logic [11:0] a, input logic [11:0] t);
    wr_byte0 = wr_fire && (a == t) && ws_q[0];
  endfunction : wr_byte0

  // ****************************************************
  // AXI4-Lite write path
  // ****************************************************
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_bresp = 2'b00;

  // ****************************************************
  // AXI4-Lite read path
  // ****************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr[11:2])
        `CTL_ONE_ADDR >> 2:
          s_axi_rdata <= {24'h0, ctl_one_q[7:4], transfer_in_progress_out, ctl_one_q[2:0]};
        `CTL_TWO_ADDR >> 2: s_axi_rdata <= {24'h0, ctl_two_q & `C2_MASK};
        `UNIT_LIMIT_ADDR >> 2: s_axi_rdata <= {28'h0, unit_count_limit_q};
        `WRAP_LEN_ADDR >> 2: s_axi_rdata <= {26'h0, expected_wrapper_length_q};
        `FAIL_STAT_ADDR >> 2: s_axi_rdata <= {24'h0, fail_q};
        `EVENT_STAT_ADDR >> 2: s_axi_rdata <= {24'h0, ev_q};
        `MEDIA_CFG_ADDR >> 2: s_axi_rdata <= {16'h0, unit_enable_q};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************************
  // Control registers
  // ****************************************************
  assign auto_on = ctl_one_q[`C1_AUTO];

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      ctl_one_q <= 8'h00;
    else
    begin
      if (wr_byte0(aw_q, `CTL_ONE_ADDR))
        ctl_one_q <= {w_q[7:4], transfer_in_progress_out, w_q[2:0]};
      // Hardware clearing the single-command bit at completion wins over a firmware write in the same cycle
      if (state_q == ST_DONE && once_run_q)
        ctl_one_q[`C1_ONCE] <= 1'b0;
      if (ctl_one_q[`C1_SOFT_RST])
        ctl_one_q[`C1_SOFT_RST] <= 1'b0;
      ctl_one_q[3] <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      ctl_two_q <= `C2_RESET;
    else if (wr_byte0(aw_q, `CTL_TWO_ADDR))
      ctl_two_q <= w_q[7:0] & `C2_MASK;
    else
      ctl_two_q[`C2_ABORT] <= 1'b0;
  end

  // Abort pulse taken directly from the write, so the bit never reads back set
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      aes_abort_out <= 1'b0;
    else
      aes_abort_out <= wr_byte0(aw_q, `CTL_TWO_ADDR) && w_q[`C2_ABORT];
  end

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      unit_count_limit_q <= 4'h0;
      expected_wrapper_length_q <= 6'h00;
      unit_enable_q <= 16'h0000;
    end
    else
    begin
      if (wr_byte0(aw_q, `UNIT_LIMIT_ADDR))
        unit_count_limit_q <= w_q[3:0];
      if (wr_byte0(aw_q, `WRAP_LEN_ADDR))
        expected_wrapper_length_q <= w_q[5:0];
      if (wr_fire && aw_q == `MEDIA_CFG_ADDR)
        unit_enable_q <= w_q[15:0];
    end
  end

  assign buffer_join_enable_out = ctl_two_q[`C2_JOIN];

  // ****************************************************
  // Wrapper checks
  // ****************************************************
  logic [7:0] chk_fail;
  logic [7:0] chk_ev;
  logic chk_err;
  always_comb
  begin
    chk_fail = {phase_err_in, data_err_in, wrapper_scsi_bad_in,
                wrapper_unit_in > unit_count_limit_q,
                ctl_one_q[`C1_RESERVED_CHECK_ENABLE] && wrapper_rsv_nonzero_in,
                wrapper_xfer_len_bad_in, wrapper_wp_bad_in, wrapper_sig_bad_in};
    chk_ev = 8'h00;
    chk_ev[`EV_UNIT_OFF] = auto_on && !unit_enable_q[wrapper_unit_in];
    chk_ev[`EV_CB_LEN] = wrapper_cb_len_bad_in;
    chk_ev[`EV_CAP] = wrapper_cap_bad_in;
    chk_ev[`EV_PKT_LEN] = wrapper_len_in != expected_wrapper_length_q;
    chk_err = (chk_fail[5:0] != 6'h00) || (chk_ev != 8'h00);
  end

  // ****************************************************
  // Sequencer
  // ****************************************************
  logic tail_on;
  logic wrap_ok;
  assign tail_on = ctl_one_q[`C1_TAIL_MODE];
  assign wrap_ok = wrapper_rx_in && (auto_on || ctl_one_q[`C1_ONCE]);

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in || ctl_one_q[`C1_SOFT_RST])
    begin
      state_q <= ST_IDLE;
      once_run_q <= 1'b0;
      tail_err_pend_q <= 1'b0;
      held_fail_q <= 8'h00;
      held_ev_q <= 8'h00;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (wrap_ok)
          begin
            once_run_q <= !auto_on;
            state_q <= ST_CHECK;
          end
        ST_CHECK:
          if (tail_on && chk_err)
          begin
            tail_err_pend_q <= 1'b1;
            held_fail_q <= chk_fail;
            held_ev_q <= chk_ev;
            state_q <= ST_TAIL;
          end
          else if (tail_on && !wrapper_continues_in)
            state_q <= ST_TAIL;
          else if (chk_err)
            state_q <= ST_DONE;
          else
            state_q <= ST_XFER;
        ST_TAIL:
          if (!ev_q[`EV_TAIL] && !ev_set[`EV_TAIL])
          begin
            tail_err_pend_q <= 1'b0;
            state_q <= tail_err_pend_q ? ST_DONE : ST_XFER;
          end
        ST_XFER:
          if (xfer_err_in || xfer_done_in)
            state_q <= ST_DONE;
        ST_DONE:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // A wrapper released from the tail stall needs its own start pulse
  assign start_xfer_out =
    (state_q == ST_CHECK && !chk_err && !(tail_on && !wrapper_continues_in))
    || (state_q == ST_TAIL && !tail_err_pend_q && !ev_q[`EV_TAIL]
        && !ev_set[`EV_TAIL]);
  assign status_wrapper_send_out = state_q == ST_DONE && ctl_one_q[`C1_AUTOMATIC_STATUS_WRAPPER_ENABLE] && !once_run_q;
  assign transfer_in_progress_out = state_q != ST_IDLE;
  assign activity_led_out = transfer_in_progress_out;

  // AES parameters leave in the cycle after the wrapper, well inside the window
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      aes_param_load_out <= 1'b0;
    else
      aes_param_load_out <= state_q == ST_IDLE && wrap_ok;
  end

  // ****************************************************
  // OUT buffer posting
  // ****************************************************
  logic [1:0] target_bufs;
  assign target_bufs = ctl_two_q[`C2_SINGLE] ? 2'd1 : 2'd2;
  assign out_buf_post_out = out_bufs_posted_out < target_bufs;

  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
      out_bufs_posted_out <= 2'd0;
    else
      out_bufs_posted_out <= out_bufs_posted_out + 2'(out_buf_post_out)
                             - 2'(out_buf_taken_in && out_bufs_posted_out != 2'd0);
  end

  // ****************************************************
  // Status registers
  // ****************************************************
  cbw_timeout #(
    .COUNT(TAIL_TIMEOUT)
  ) u_timeout (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .run_in(tail_on && state_q == ST_IDLE),
    .restart_in(media_access_in),
    .expired_out(timeout_hit)
  );

  logic err_release;
  assign err_release = state_q == ST_TAIL && tail_err_pend_q && !ev_q[`EV_TAIL];

  always_comb
  begin
    fail_set = 8'h00;
    if (auto_on)
    begin
      if (state_q == ST_CHECK && !(tail_on && chk_err))
        fail_set = chk_fail;
      else if (err_release)
        fail_set = held_fail_q;
    end
    ev_set = 8'h00;
    if (state_q == ST_CHECK && !(tail_on && chk_err))
      ev_set = chk_ev;
    else if (err_release)
      ev_set = held_ev_q;
    ev_set[`EV_TAIL] = tail_on && ((state_q == ST_CHECK && (chk_err || !wrapper_continues_in))
                       || (state_q == ST_XFER && xfer_err_in) || timeout_hit);
    ev_set[`EV_IDLE] = state_q == ST_IDLE && !auto_on;
    ev_set[`EV_ONCE] = state_q == ST_DONE && (once_run_q || !ctl_one_q[`C1_AUTOMATIC_STATUS_WRAPPER_ENABLE]);
    fail_clr = wr_byte0(aw_q, `FAIL_STAT_ADDR) ? w_q[7:0] : 8'h00;
    ev_clr = wr_byte0(aw_q, `EVENT_STAT_ADDR) ? (w_q[7:0] & 8'h7f) : 8'h00;
  end

  cbw_w1c_reg #(
    .WIDTH(8)
  ) u_fail (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(fail_set),
    .clr_in(fail_clr),
    .flags_out(fail_q)
  );

  cbw_w1c_reg #(
    .WIDTH(8)
  ) u_event (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(ev_set & 8'h7f),
    .clr_in(ev_clr),
    .flags_out(ev_q)
  );

  assign command_processor_irq_out = fail_q != 8'h00;
  assign single_command_done_irq_out = ev_q[`EV_ONCE];
  assign event_irq_out = ev_q != 8'h00;
endmodule : cbw_processor
`default_nettype wire

// *** dv/cbw_processor_props.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************
// Port checks
// ****************
module cbw_processor_props (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic out_buf_post_out,
  input wire logic out_buf_taken_in,
  input wire logic [1:0] out_bufs_posted_out,
  input wire logic buffer_join_enable_out,
  input wire logic aes_abort_out,
  input wire logic aes_param_load_out,
  input wire logic start_xfer_out,
  input wire logic status_wrapper_send_out,
  input wire logic transfer_in_progress_out,
  input wire logic activity_led_out
);
  default clocking dc @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);
  a_led_mirror: assert property (activity_led_out == transfer_in_progress_out)
    else $error("led differs from busy");
  a_start_busy: assert property (start_xfer_out |-> transfer_in_progress_out)
    else $error("start while idle");
  a_param_soon: assert property ($rose(transfer_in_progress_out) |-> ##[0:29] aes_param_load_out)
    else $error("aes parameters late");
  a_abort_pulse: assert property (aes_abort_out |=> !aes_abort_out)
    else $error("abort not self clearing");
  a_join_reset: assert property ($fell(sys_rst_in) |-> buffer_join_enable_out)
    else $error("join off after reset");
  a_post_limit: assert property (out_bufs_posted_out <= 2'd2)
    else $error("too many buffers");
  a_post_count: assert property (out_buf_post_out && !out_buf_taken_in |=>
    out_bufs_posted_out == $past(out_bufs_posted_out) + 2'd1)
    else $error("post not counted");
  a_send_ends: assert property (status_wrapper_send_out |=> !transfer_in_progress_out)
    else $error("busy after status");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
endmodule : cbw_processor_props
bind cbw_processor cbw_processor_props i_cbw_processor_props (.*);
`default_nettype wire

// *** dv/cbw_engine_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************
// Serial engine stand-in
// ****************
module cbw_engine_model (
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic send_in,
  input wire logic [3:0] err_in,
  input wire logic [5:0] len_in,
  input wire logic cont_in,
  input wire logic take_in,
  input wire logic [3:0] dly_in,
  input wire logic start_xfer_out,
  input wire logic [1:0] out_bufs_posted_out,
  output logic wrapper_rx_in,
  output logic [5:0] wrapper_len_in,
  output logic [3:0] wrapper_unit_in,
  output logic wrapper_rsv_nonzero_in,
  output logic wrapper_sig_bad_in,
  output logic wrapper_cb_len_bad_in,
  output logic wrapper_xfer_len_bad_in,
  output logic wrapper_scsi_bad_in,
  output logic wrapper_cap_bad_in,
  output logic wrapper_wp_bad_in,
  output logic wrapper_continues_in,
  output logic phase_err_in,
  output logic data_err_in,
  output logic xfer_err_in,
  output logic xfer_done_in,
  output logic media_access_in,
  output logic out_buf_taken_in
);
  logic [10:0] e;
  logic [3:0] cnt_q;
  assign e = 11'h1 << err_in;
  assign xfer_err_in = 1'b0;
  always_ff @(posedge mclk_in)
  begin
    if (sys_rst_in)
    begin
      wrapper_rx_in <= 1'b0;
      cnt_q <= 4'h0;
      xfer_done_in <= 1'b0;
      media_access_in <= 1'b0;
      out_buf_taken_in <= 1'b0;
    end
    else
    begin
      wrapper_rx_in <= send_in;
      out_buf_taken_in <= take_in && out_bufs_posted_out != 2'd0;
      media_access_in <= cnt_q != 4'h0;
      xfer_done_in <= cnt_q == 4'h1;
      if (start_xfer_out)
        cnt_q <= dly_in;
      else if (cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
    end
  end
  // Fields held until the next wrapper: sampled late by the checker state
  always_ff @(posedge mclk_in)
    if (send_in)
    begin
      wrapper_len_in <= len_in;
      wrapper_continues_in <= cont_in;
      wrapper_unit_in <= e[5] ? 4'h9 : 4'h0;
      {wrapper_cap_bad_in, wrapper_cb_len_bad_in, phase_err_in, data_err_in} <= e[10:7];
      {wrapper_scsi_bad_in, wrapper_rsv_nonzero_in, wrapper_xfer_len_bad_in} <= {e[6], e[4:3]};
      {wrapper_wp_bad_in, wrapper_sig_bad_in} <= e[2:1];
    end
endmodule : cbw_engine_model
`default_nettype wire

// *** dv/tb_cbw_processor.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_cbw_processor import cbw_pkg::*; ;
  logic mclk_in = 1'b0, sys_rst_in = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf, err_in = 4'h0, dly_in = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, out_bufs_posted_out;
  logic [5:0] len_in = 6'h1f, wrapper_len_in;
  logic [3:0] wrapper_unit_in;
  logic send_in = 1'b0, cont_in = 1'b1, take_in = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic wrapper_rx_in, wrapper_rsv_nonzero_in, wrapper_sig_bad_in, wrapper_cb_len_bad_in;
  logic wrapper_xfer_len_bad_in, wrapper_scsi_bad_in, wrapper_cap_bad_in, wrapper_wp_bad_in;
  logic wrapper_continues_in, phase_err_in, data_err_in, xfer_err_in, xfer_done_in;
  logic media_access_in, out_buf_taken_in, out_buf_post_out, buffer_join_enable_out;
  logic aes_abort_out, aes_param_load_out, start_xfer_out, status_wrapper_send_out;
  logic transfer_in_progress_out, activity_led_out, single_command_done_irq_out;
  logic command_processor_irq_out, event_irq_out;
  int err_count = 0, num_checks = 0, ab_n = 0, st_n = 0, sw_n = 0, n;
  // Short timeout keeps the idle-traffic case inside the run
  cbw_processor #(.TAIL_TIMEOUT(2000)) i_cbw_processor (.*);
  cbw_engine_model i_cbw_engine_model (.*);
  initial forever #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    if (aes_abort_out) ab_n++;
    if (start_xfer_out) st_n++;
    if (status_wrapper_send_out) sw_n++;
  end
  // ****************
  // Access tasks
  // ****************
  task automatic chk(input reg_byte_t s, input reg_byte_t e);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge mclk_in);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
  endtask : wr
  task automatic rd(input logic [11:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge mclk_in);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  task automatic rc(input logic [11:0] a, input reg_byte_t e, input reg_byte_t m);
    rd(a);
    chk(d[7:0] & m, e);
  endtask : rc
  // Waits out the check state, then for idle unless a stall is expected
  task automatic wrap(input logic [3:0] e, input logic c, input logic w);
    send_in <= 1'b1;
    err_in <= e;
    cont_in <= c;
    @(posedge mclk_in);
    send_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    while (w && transfer_in_progress_out) @(posedge mclk_in);
  endtask : wrap
  task automatic final_report;
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    final_report();
  end
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    rc(12'h004, 8'h04, 8'hff);
    rc(12'h020, 8'h00, 8'hff);
    rc(12'h028, 8'h04, 8'hff);
    chk(out_bufs_posted_out, 8'h2);
    rd(12'h100);
    chk(r, 8'h2);
    chk(d[7:0], 8'h00);
    wr(12'h004, 8'hff);
    rc(12'h004, 8'h05, 8'hff);
    chk(ab_n, 8'h1);
    take_in <= 1'b1;
    repeat (6) @(posedge mclk_in);
    take_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk(out_bufs_posted_out, 8'h1);
    wr(12'h004, 8'h00);
    chk(buffer_join_enable_out, 8'h0);
    @(posedge mclk_in);
    chk(out_bufs_posted_out, 8'h2);
    wr(12'h004, 8'h04);
    wr(12'h00c, 8'h1f);
    wr(12'h008, 8'h03);
    wr(12'h030, 8'hff);
    dly_in <= 4'h6;
    wr(12'h000, 8'h20);
    wrap(4'h0, 1'b1, 1'b1);
    rc(12'h000, 8'h00, 8'hff);
    chk(st_n, 8'h1);
    chk(single_command_done_irq_out, 8'h1);
    rc(12'h028, 8'h05, 8'hff);
    chk(event_irq_out, 8'h1);
    wr(12'h028, 8'h01);
    chk(single_command_done_irq_out, 8'h0);
    wr(12'h000, 8'h20);
    wrap(4'h1, 1'b1, 1'b1);
    rc(12'h020, 8'h00, 8'hff);
    dly_in <= 4'h1;
    wr(12'h000, 8'h82);
    for (int k = 1; k <= 8; k++)
    begin
      wrap(k[3:0], 1'b1, 1'b1);
      rc(12'h020, 8'h01 << (k - 1), 8'hff);
      chk(command_processor_irq_out, 8'h1);
      wr(12'h020, 8'h00);
      rc(12'h020, 8'h01 << (k - 1), 8'hff);
      wr(12'h020, 8'hff);
      rc(12'h020, 8'h00, 8'hff);
    end
    wr(12'h028, 8'hff);
    wrap(4'h0, 1'b1, 1'b1);
    rc(12'h028, 8'h01, 8'h01);
    wr(12'h000, 8'hc2);
    wr(12'h028, 8'hff);
    wrap(4'h0, 1'b1, 1'b1);
    chk(sw_n, 8'h1);
    rc(12'h028, 8'h00, 8'h01);
    wrap(4'h9, 1'b1, 1'b1);
    rc(12'h028, 8'h10, 8'h18);
    wr(12'h028, 8'h18);
    wrap(4'ha, 1'b1, 1'b1);
    rc(12'h028, 8'h08, 8'h18);
    len_in <= 6'h10;
    wrap(4'h0, 1'b1, 1'b1);
    rc(12'h028, 8'h02, 8'h02);
    len_in <= 6'h1f;
    wr(12'h028, 8'hff);
    wr(12'h000, 8'h84);
    n = st_n;
    wrap(4'h0, 1'b0, 1'b0);
    rc(12'h028, 8'h40, 8'h40);
    chk(st_n - n, 8'h0);
    wr(12'h028, 8'h40);
    while (transfer_in_progress_out) @(posedge mclk_in);
    wrap(4'h1, 1'b1, 1'b0);
    chk(st_n - n, 8'h1);
    rc(12'h028, 8'h40, 8'h40);
    rc(12'h020, 8'h00, 8'hff);
    wr(12'h028, 8'h40);
    repeat (4) @(posedge mclk_in);
    rc(12'h020, 8'h01, 8'hff);
    repeat (2100) @(posedge mclk_in);
    rc(12'h028, 8'h40, 8'h40);
    wr(12'h000, 8'h85);
    rc(12'h000, 8'h84, 8'hff);
    final_report();
  end
endmodule : tb_cbw_processor
`default_nettype wire
